// >>> rtl/hbadt_dev.sv
// bus transfer engine and the controller end of the front-side bus
// =====================================================================
// Summary of operation
// (RULE1) data supplier flags valid while data moves
// (RULE2) early read notice one bus clock before data
// (RULE3) processor cycles: controller never drives address
// (RULE4) controller drives address for snoop cycles
// (RULE5) address moves as two beats per bus clock
// (RULE6) address strobes sent and used for capture
// (RULE7) 64-bit data moves as four beats
// (RULE8) receiver undoes inversion per 16-bit group
// (RULE9) four strobe pairs toggle with data, flags
// (RULE10) capture on falling edges, pair strobes alternate
// (RULE11) at most eight low bits per group
// (RULE12) captured beats delivered together once per transfer
`timescale 1ns/100ps

// =====================================================================
// shared transfer engine
module hbadt_xfer
   import hbadt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // bus lines
   input wire logic bclk_i,
   input wire hbadt_pins_t line_i,
   output hbadt_pins_t pins_o,
   output hbadt_oe_t oe_o,
   output logic bclk_rise_o,
   // address send
   input wire logic a_go_i,
   input wire hbadt_abeats_t a_beats_i,
   output logic a_busy_o,
   output logic a_done_o,
   // data send
   input wire logic d_go_i,
   input wire hbadt_dbeats_t d_beats_i,
   output logic d_busy_o,
   output logic d_done_o,
   // receive
   output logic a_rx_valid_o,
   output hbadt_abeats_t a_rx_o,
   output logic d_rx_valid_o,
   output hbadt_dbeats_t d_rx_o
);
   // =====================================================================
   // bus clock edge finder
   logic [2:0] bclk_q;
   wire bclk_rise = bclk_q[1] & ~bclk_q[2];
   assign bclk_rise_o = bclk_rise;

   always_ff @(posedge clk_i) begin
      if (srst_i) bclk_q <= BCLK_RST;
      else bclk_q <= {bclk_q[1:0], bclk_i};
   end

   // =====================================================================
   // address send
   hbadt_abeats_t a_buf_q;
   logic a_pend_q, a_act_q, a_busy_q, a_done_q, a_oe_q;
   logic [1:0] a_cnt_q;
   logic [ASTB_N-1:0] astb_q;
   hbadt_addr_t addr_q;
   wire [1:0] a_nxt = a_cnt_q + 2'h1;
   wire a_start = a_pend_q & bclk_rise;
   wire a_end = a_act_q & (a_cnt_q == A_LAST);
   wire a_take = a_go_i & ~a_busy_q;
   wire a_sel = a_act_q & a_nxt[1];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         a_pend_q <= 1'b0;
         a_act_q <= 1'b0;
         a_busy_q <= 1'b0;
         a_done_q <= 1'b0;
         a_cnt_q <= ACNT_RST;
         a_buf_q <= '0;
      end else begin
         a_pend_q <= (a_pend_q & ~bclk_rise) | a_take;
         a_act_q <= a_start | (a_act_q & ~a_end);
         a_busy_q <= (a_busy_q & ~a_end) | a_take;
         a_done_q <= a_end;
         a_cnt_q <= a_act_q ? a_nxt : ACNT_RST;
         if (a_take) a_buf_q <= a_beats_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         addr_q <= '0;
         astb_q <= STB_A_IDLE;
         a_oe_q <= 1'b0;
      end else if (a_start) begin
         addr_q <= a_buf_q[0];
         a_oe_q <= 1'b1;
      end else if (a_end) begin
         astb_q <= STB_A_IDLE;
         a_oe_q <= 1'b0;
      end else if (a_act_q & a_nxt[0]) begin
         astb_q <= ~(2'h1 << a_nxt[1]);  // see (RULE6)
      end else if (a_act_q) begin
         addr_q <= a_buf_q[a_sel];  // see (RULE5)
      end
   end

   // =====================================================================
   // data send
   hbadt_dbeats_t d_buf_q;
   logic d_pend_q, d_act_q, d_busy_q, d_done_q, d_oe_q;
   logic [2:0] d_cnt_q;
   logic [GRP_N-1:0] stbp_q, stbn_q;
   hbadt_dbi_t dout_q;
   wire [2:0] d_nxt = d_cnt_q + 3'h1;
   wire d_start = d_pend_q & bclk_rise;
   wire d_end = d_act_q & (d_cnt_q == D_LAST);
   wire d_take = d_go_i & ~d_busy_q;
   wire [1:0] d_sel = d_act_q ? d_nxt[2:1] : 2'h0;
   hbadt_dbi_t d_enc;
   assign d_enc = dbi_encode(d_buf_q[d_sel]);  // see (RULE11)

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         d_pend_q <= 1'b0;
         d_act_q <= 1'b0;
         d_busy_q <= 1'b0;
         d_done_q <= 1'b0;
         d_cnt_q <= DCNT_RST;
         d_buf_q <= '0;
      end else begin
         d_pend_q <= (d_pend_q & ~bclk_rise) | d_take;
         d_act_q <= d_start | (d_act_q & ~d_end);
         d_busy_q <= (d_busy_q & ~d_end) | d_take;
         d_done_q <= d_end;
         d_cnt_q <= d_act_q ? d_nxt : DCNT_RST;
         if (d_take) d_buf_q <= d_beats_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dout_q <= '0;
         stbp_q <= STB_D_IDLE;
         stbn_q <= STB_D_IDLE;
         d_oe_q <= 1'b0;
      end else if (d_start) begin
         dout_q <= d_enc;
         d_oe_q <= 1'b1;  // see (RULE1)
      end else if (d_end) begin
         stbp_q <= STB_D_IDLE;
         stbn_q <= STB_D_IDLE;
         d_oe_q <= 1'b0;  // see (RULE1)
      end else if (d_act_q & d_nxt[0]) begin
         stbp_q <= {GRP_N{d_nxt[1]}};  // see (RULE9)
         stbn_q <= {GRP_N{~d_nxt[1]}};
      end else if (d_act_q) begin
         dout_q <= d_enc;  // see (RULE7)
      end
   end

   assign pins_o = '{
      host_address_lines: addr_q,
      address_source_strobes: astb_q,
      host_data_lines: dout_q.data,
      data_group_inversion_flags: dout_q.inv,
      data_strobe_true: stbp_q,
      data_strobe_complement: stbn_q,
      host_data_valid: d_oe_q
   };
   assign oe_o = '{address: a_oe_q, data: d_oe_q};
   assign a_busy_o = a_busy_q;
   assign a_done_o = a_done_q;
   assign d_busy_o = d_busy_q;
   assign d_done_o = d_done_q;

   // =====================================================================
   // receive: line sampling, own traffic masked
   hbadt_pins_t s1_q, s2_q;
   logic [ASTB_N-1:0] astb3_q;
   logic [GRP_N-1:0] p3_q, n3_q;
   logic dv3_q;
   logic [OWN_W-1:0] a_own_q, d_own_q;
   wire a_mute = a_act_q | (|a_own_q);
   wire d_mute = d_act_q | (|d_own_q);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_q <= PINS_IDLE;
         s2_q <= PINS_IDLE;
         astb3_q <= STB_A_IDLE;
         p3_q <= STB_D_IDLE;
         n3_q <= STB_D_IDLE;
         dv3_q <= 1'b0;
         a_own_q <= OWN_RST;
         d_own_q <= OWN_RST;
      end else begin
         s1_q <= line_i;
         s2_q <= s1_q;
         astb3_q <= s2_q.address_source_strobes;
         p3_q <= s2_q.data_strobe_true;
         n3_q <= s2_q.data_strobe_complement;
         dv3_q <= s2_q.host_data_valid;
         a_own_q <= {a_own_q[OWN_W-2:0], a_act_q};
         d_own_q <= {d_own_q[OWN_W-2:0], d_act_q};
      end
   end

   // =====================================================================
   // receive: address beats
   wire [ASTB_N-1:0] a_fall = astb3_q & ~s2_q.address_source_strobes & {ASTB_N{~a_mute}};
   hbadt_abeats_t a_rx_q;
   logic a_rx_valid_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         a_rx_q <= '0;
         a_rx_valid_q <= 1'b0;
      end else begin
         for (int k = 0; k < ABEATS; k++) begin
            if (a_fall[k]) a_rx_q[k] <= s2_q.host_address_lines;  // see (RULE6)
         end
         a_rx_valid_q <= a_fall[ASTB_N-1];  // see (RULE12)
      end
   end

   // =====================================================================
   // receive: data beats per group
   wire [GRP_N-1:0] p_fall = p3_q & ~s2_q.data_strobe_true;
   wire [GRP_N-1:0] n_fall = n3_q & ~s2_q.data_strobe_complement;
   wire [GRP_N-1:0] g_fall = (p_fall | n_fall) & {GRP_N{~d_mute}};
   wire d_fire = dv3_q & ~s2_q.host_data_valid & ~d_mute;
   logic [1:0] g_cnt_q [GRP_N];
   hbadt_dbeats_t d_acc_q, d_rx_q;
   logic d_rx_valid_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         for (int g = 0; g < GRP_N; g++) g_cnt_q[g] <= GCNT_RST;
         d_acc_q <= '0;
      end else begin
         for (int g = 0; g < GRP_N; g++) begin
            if (~s2_q.host_data_valid) begin
               g_cnt_q[g] <= GCNT_RST;
            end else if (g_fall[g]) begin  // see (RULE10)
               d_acc_q[g_cnt_q[g]][g*GRP_W +: GRP_W] <=
                  s2_q.host_data_lines[g*GRP_W +: GRP_W] ^
                  {GRP_W{s2_q.data_group_inversion_flags[g]}};  // see (RULE8)
               g_cnt_q[g] <= g_cnt_q[g] + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         d_rx_q <= '0;
         d_rx_valid_q <= 1'b0;
      end else begin
         if (d_fire) d_rx_q <= d_acc_q;  // see (RULE12)
         d_rx_valid_q <= d_fire;
      end
   end

   assign a_rx_o = a_rx_q;
   assign a_rx_valid_o = a_rx_valid_q;
   assign d_rx_o = d_rx_q;
   assign d_rx_valid_o = d_rx_valid_q;
endmodule

// =====================================================================
// controller end
module hbadt_dev
   import hbadt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // front-side bus
   hbadt_if.dev bus,
   // snoop address issue
   input wire logic snoop_go_i,
   input wire hbadt_abeats_t snoop_addr_i,
   output logic snoop_busy_o,
   output logic snoop_done_o,
   // read data return
   input wire logic rd_req_i,
   input wire hbadt_dbeats_t rd_data_i,
   output logic rd_ack_o,
   output logic rd_done_o,
   // processor cycles received
   output logic cpu_addr_valid_o,
   output hbadt_abeats_t cpu_addr_o,
   output logic wr_data_valid_o,
   output hbadt_dbeats_t wr_data_o
);
   logic bclk_rise, d_busy, d_done;
   hbadt_rd_state_t st_q;
   logic notice_q, ack_q;
   wire rd_take = (st_q == RD_IDLE) & rd_req_i & ~d_busy & bclk_rise;

   // =====================================================================
   // read return: notice for one bus clock, then data
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q <= RD_IDLE;
         notice_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         ack_q <= rd_take;
         case (st_q)
            RD_IDLE: begin
               if (rd_take) begin
                  st_q <= RD_NOTICE;
                  notice_q <= 1'b1;  // see (RULE2)
               end
            end
            RD_NOTICE: begin
               if (bclk_rise) begin
                  st_q <= RD_DATA;
                  notice_q <= 1'b0;  // see (RULE2)
               end
            end
            RD_DATA: begin
               if (d_done) st_q <= RD_IDLE;
            end
            default: st_q <= RD_IDLE;
         endcase
      end
   end

   assign bus.early_read_data_notice = notice_q;
   assign rd_ack_o = ack_q;
   assign rd_done_o = d_done;

   // address lines driven only by snoop sends, see (RULE3) and (RULE4)
   hbadt_xfer u_xfer (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .bclk_i(bus.bclk),
      .line_i(bus.line),
      .pins_o(bus.dev_pins),
      .oe_o(bus.dev_oe),
      .bclk_rise_o(bclk_rise),
      .a_go_i(snoop_go_i),
      .a_beats_i(snoop_addr_i),
      .a_busy_o(snoop_busy_o),
      .a_done_o(snoop_done_o),
      .d_go_i(rd_take),
      .d_beats_i(rd_data_i),
      .d_busy_o(d_busy),
      .d_done_o(d_done),
      .a_rx_valid_o(cpu_addr_valid_o),
      .a_rx_o(cpu_addr_o),
      .d_rx_valid_o(wr_data_valid_o),
      .d_rx_o(wr_data_o)
   );
endmodule

// >>> rtl/hbadt_host.sv
// processor end of the front-side bus
`timescale 1ns/100ps
module hbadt_host
   import hbadt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // front-side bus
   hbadt_if.host bus,
   // processor request address
   input wire logic cpu_go_i,
   input wire hbadt_abeats_t cpu_addr_i,
   output logic cpu_busy_o,
   output logic cpu_done_o,
   // write data
   input wire logic wr_go_i,
   input wire hbadt_dbeats_t wr_data_i,
   output logic wr_busy_o,
   output logic wr_done_o,
   // received snoops, read data and notice
   output logic snoop_valid_o,
   output hbadt_abeats_t snoop_addr_o,
   output logic rd_valid_o,
   output hbadt_dbeats_t rd_data_o,
   output logic rd_early_o
);
   // =====================================================================
   // notice sampling
   logic [1:0] early_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) early_q <= 2'h0;
      else early_q <= {early_q[0], bus.early_read_data_notice};
   end

   assign rd_early_o = early_q[1];

   // =====================================================================
   // transfer engine, processor roles: see (RULE3) (RULE5) (RULE7)
   hbadt_xfer u_xfer (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .bclk_i(bus.bclk),
      .line_i(bus.line),
      .pins_o(bus.host_pins),
      .oe_o(bus.host_oe),
      .bclk_rise_o(),
      .a_go_i(cpu_go_i),
      .a_beats_i(cpu_addr_i),
      .a_busy_o(cpu_busy_o),
      .a_done_o(cpu_done_o),
      .d_go_i(wr_go_i),
      .d_beats_i(wr_data_i),
      .d_busy_o(wr_busy_o),
      .d_done_o(wr_done_o),
      .a_rx_valid_o(snoop_valid_o),
      .a_rx_o(snoop_addr_o),
      .d_rx_valid_o(rd_valid_o),
      .d_rx_o(rd_data_o)
   );
endmodule

// >>> rtl/hbadt_if.sv
// bus wires between the controller end and the processor end
`timescale 1ns/100ps
interface hbadt_if;
   import hbadt_pkg::*;

   logic bclk;
   logic early_read_data_notice;
   hbadt_pins_t dev_pins;
   hbadt_pins_t host_pins;
   hbadt_oe_t dev_oe;
   hbadt_oe_t host_oe;
   hbadt_pins_t line;

   // =====================================================================
   // wire resolution; undriven lines rest at their idle level
   assign line = '{
      host_address_lines: dev_oe.address ? dev_pins.host_address_lines :
         host_oe.address ? host_pins.host_address_lines : PINS_IDLE.host_address_lines,
      address_source_strobes: dev_oe.address ? dev_pins.address_source_strobes :
         host_oe.address ? host_pins.address_source_strobes :
         PINS_IDLE.address_source_strobes,
      host_data_lines: dev_oe.data ? dev_pins.host_data_lines :
         host_oe.data ? host_pins.host_data_lines : PINS_IDLE.host_data_lines,
      data_group_inversion_flags: dev_oe.data ? dev_pins.data_group_inversion_flags :
         host_oe.data ? host_pins.data_group_inversion_flags :
         PINS_IDLE.data_group_inversion_flags,
      data_strobe_true: dev_oe.data ? dev_pins.data_strobe_true :
         host_oe.data ? host_pins.data_strobe_true : PINS_IDLE.data_strobe_true,
      data_strobe_complement: dev_oe.data ? dev_pins.data_strobe_complement :
         host_oe.data ? host_pins.data_strobe_complement :
         PINS_IDLE.data_strobe_complement,
      host_data_valid: dev_oe.data ? dev_pins.host_data_valid :
         host_oe.data ? host_pins.host_data_valid : PINS_IDLE.host_data_valid
   };

   modport dev (input bclk, input line, output dev_pins, output dev_oe,
      output early_read_data_notice);
   modport host (input bclk, input line, input early_read_data_notice,
      output host_pins, output host_oe);
endinterface

// >>> rtl/hbadt_pkg.sv
// constants, types and inversion coding shared by both bus ends
package hbadt_pkg;

   // =====================================================================
   // widths and beat counts
   localparam int ADDR_W = 29;
   localparam int DATA_W = 64;
   localparam int GRP_N = 4;
   localparam int GRP_W = 16;
   localparam int MAX_LOW = 8;
   localparam int ASTB_N = 2;
   localparam int ABEATS = 2;
   localparam int DBEATS = 4;
   // one cycle to set the lines, one to drop the strobe
   localparam int BEAT_CYC = 2;
   localparam int OWN_W = 4;

   // =====================================================================
   // counter limits and reset values
   localparam logic [1:0] A_LAST = 2'(ABEATS * BEAT_CYC - 1);
   localparam logic [2:0] D_LAST = 3'(DBEATS * BEAT_CYC - 1);
   localparam logic [1:0] ACNT_RST = 2'h0;
   localparam logic [2:0] DCNT_RST = 3'h0;
   localparam logic [1:0] GCNT_RST = 2'h0;
   // edge finder rests high: no false bus clock rise after reset
   localparam logic [2:0] BCLK_RST = 3'h7;
   localparam logic [OWN_W-1:0] OWN_RST = 4'h0;
   localparam logic [ASTB_N-1:0] STB_A_IDLE = 2'h3;
   localparam logic [GRP_N-1:0] STB_D_IDLE = 4'hf;

   // =====================================================================
   // types
   typedef logic [ADDR_W-1:0] hbadt_addr_t;
   typedef hbadt_addr_t [ABEATS-1:0] hbadt_abeats_t;
   typedef logic [DATA_W-1:0] hbadt_data_t;
   typedef hbadt_data_t [DBEATS-1:0] hbadt_dbeats_t;

   typedef struct packed {
      hbadt_addr_t host_address_lines;
      logic [ASTB_N-1:0] address_source_strobes;
      hbadt_data_t host_data_lines;
      logic [GRP_N-1:0] data_group_inversion_flags;
      logic [GRP_N-1:0] data_strobe_true;
      logic [GRP_N-1:0] data_strobe_complement;
      logic host_data_valid;
   } hbadt_pins_t;

   typedef struct packed {
      logic address;
      logic data;
   } hbadt_oe_t;

   typedef struct packed {
      logic [GRP_N-1:0] inv;
      hbadt_data_t data;
   } hbadt_dbi_t;

   typedef enum logic [2:0] {
      RD_IDLE = 3'h1,
      RD_NOTICE = 3'h2,
      RD_DATA = 3'h4
   } hbadt_rd_state_t;

   localparam hbadt_pins_t PINS_IDLE = '{
      host_address_lines: '0,
      address_source_strobes: STB_A_IDLE,
      host_data_lines: '0,
      data_group_inversion_flags: '0,
      data_strobe_true: STB_D_IDLE,
      data_strobe_complement: STB_D_IDLE,
      host_data_valid: 1'b0
   };

   // =====================================================================
   // invert a group when more than half its bits would be low
   function automatic hbadt_dbi_t dbi_encode(input hbadt_data_t v);
      hbadt_dbi_t r;
      logic [4:0] zeros;
      r = '0;
      for (int g = 0; g < GRP_N; g++) begin
         zeros = 5'h00;
         for (int b = 0; b < GRP_W; b++) begin
            zeros = zeros + {4'h0, ~v[g*GRP_W+b]};
         end
         r.inv[g] = (zeros > 5'(MAX_LOW));
         r.data[g*GRP_W +: GRP_W] = v[g*GRP_W +: GRP_W] ^ {GRP_W{r.inv[g]}};
      end
      return r;
   endfunction

endpackage

// >>> sim/hbadt_checker.sv
// concurrent checks on the bus wires between the two ends
`timescale 1ns/100ps
module hbadt_checker
   import hbadt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // bus wires
   input wire logic early_read_data_notice,
   input wire hbadt_oe_t dev_oe,
   input wire hbadt_oe_t host_oe,
   input wire hbadt_pins_t line
);
   // =====================================================================
   // helpers
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   logic [1:0] astb_q;
   logic [7:0] dstb_q;
   wire any_a = dev_oe.address | host_oe.address;
   wire any_d = dev_oe.data | host_oe.data;
   wire [7:0] dstb = {line.data_strobe_true, line.data_strobe_complement};
   wire a_fall = |(astb_q & ~line.address_source_strobes);
   wire d_fall = |(dstb_q & ~dstb);
   always_ff @(posedge clk_i) begin
      astb_q <= line.address_source_strobes;
      dstb_q <= dstb;
   end

   // =====================================================================
   // properties
   property p_valid_span;
      $rose(any_d) |-> (any_d && line.host_data_valid) [*8] ##1 !(any_d || line.host_data_valid);
   endproperty
   property p_one_data_driver;
      !(dev_oe.data && host_oe.data);
   endproperty
   property p_notice_len;
      $rose(early_read_data_notice) |-> ##[7:10] $fell(early_read_data_notice);
   endproperty
   property p_notice_data;
      $fell(early_read_data_notice) |-> dev_oe.data && line.host_data_valid;
   endproperty
   property p_addr_input;
      host_oe.address |-> !dev_oe.address;
   endproperty
   property p_addr_seq;
      $rose(any_a) |-> ##1 line.address_source_strobes == 2'h2
         ##2 line.address_source_strobes == 2'h1
         ##1 !any_a && line.address_source_strobes == STB_A_IDLE;
   endproperty
   property p_addr_hold;
      a_fall |-> $stable(line.host_address_lines);
   endproperty
   property p_dstb_seq;
      $rose(any_d) |-> ##1 dstb == 8'h0f ##2 dstb == 8'hf0 ##2 dstb == 8'h0f ##2 dstb == 8'hf0
         ##1 dstb == 8'hff;
   endproperty
   property p_data_hold;
      d_fall |-> $stable(line.host_data_lines) && $stable(line.data_group_inversion_flags);
   endproperty
   property p_low_count;
      line.host_data_valid |-> $countones(~line.host_data_lines[15:0]) <= MAX_LOW
         && $countones(~line.host_data_lines[31:16]) <= MAX_LOW
         && $countones(~line.host_data_lines[47:32]) <= MAX_LOW
         && $countones(~line.host_data_lines[63:48]) <= MAX_LOW;
   endproperty

   // =====================================================================
   // assertions and covers
   a_valid_span: assert property (p_valid_span) else $error("valid span");
   a_one_data_driver: assert property (p_one_data_driver) else $error("two drivers");
   a_notice_len: assert property (p_notice_len) else $error("notice length wrong");
   a_notice_data: assert property (p_notice_data) else $error("no data after notice");
   a_addr_input: assert property (p_addr_input) else $error("address driven twice");
   a_addr_seq: assert property (p_addr_seq) else $error("address beats wrong");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved at strobe");
   a_dstb_seq: assert property (p_dstb_seq) else $error("data strobes wrong");
   a_data_hold: assert property (p_data_hold) else $error("data moved at strobe");
   a_low_count: assert property (p_low_count) else $error("too many low bits");
   c_read: cover property ($fell(early_read_data_notice));
   c_snoop: cover property ($rose(dev_oe.address));
   c_write: cover property ($rose(host_oe.data));
endmodule

// >>> sim/test_host_bus_addr_data_transfer.sv
// self-checking bench joining the controller end and the processor end
`timescale 1ns/100ps
module test_host_bus_addr_data_transfer
   import hbadt_pkg::*;
;
   typedef struct packed {
      hbadt_addr_t a;
      hbadt_data_t d;
      logic [GRP_N-1:0] inv;
   } hbadt_row_t;
   // address, beat-0 data and its expected group inversion
   localparam hbadt_row_t ROWS [4] = '{
      '{29'h1fff_ffff, 64'h007f_00ff_0000_ffff, 4'ha},
      '{29'h0000_0000, 64'hffff_0000_00ff_007f, 4'h5},
      '{29'h0246_8ace, 64'h0123_4567_89ab_cdef, 4'h8},
      '{29'h1555_5555, 64'h0000_0000_0000_0000, 4'hf}
   };
   logic clk_i, srst_i, snoop_go_i, rd_req_i, cpu_go_i, wr_go_i;
   logic snoop_busy_o, snoop_done_o, rd_ack_o, rd_done_o, cpu_addr_valid_o, wr_data_valid_o;
   logic cpu_busy_o, cpu_done_o, wr_busy_o, wr_done_o, snoop_valid_o, rd_valid_o, rd_early_o;
   hbadt_abeats_t snoop_addr_i, cpu_addr_i, cpu_addr_o, snoop_addr_o;
   hbadt_dbeats_t rd_data_i, wr_data_i, wr_data_o, rd_data_o;
   logic [GRP_N-1:0] inv0;
   logic dv_q, early_seen;
   int fail_count, comparisons, cnt, dones;

   // =====================================================================
   // both ends, wires and checker
   hbadt_if u_hbadt_if();
   hbadt_dev u_hbadt_dev(.clk_i, .srst_i, .bus(u_hbadt_if.dev), .snoop_go_i, .snoop_addr_i,
      .snoop_busy_o, .snoop_done_o, .rd_req_i, .rd_data_i, .rd_ack_o, .rd_done_o,
      .cpu_addr_valid_o, .cpu_addr_o, .wr_data_valid_o, .wr_data_o);
   hbadt_host u_hbadt_host(.clk_i, .srst_i, .bus(u_hbadt_if.host), .cpu_go_i, .cpu_addr_i,
      .cpu_busy_o, .cpu_done_o, .wr_go_i, .wr_data_i, .wr_busy_o, .wr_done_o, .snoop_valid_o,
      .snoop_addr_o, .rd_valid_o, .rd_data_o, .rd_early_o);
   hbadt_checker u_hbadt_checker(.clk_i, .srst_i,
      .early_read_data_notice(u_hbadt_if.early_read_data_notice), .dev_oe(u_hbadt_if.dev_oe),
      .host_oe(u_hbadt_if.host_oe), .line(u_hbadt_if.line));

   // =====================================================================
   // clocks and wire monitor
   always #2.5 clk_i = ~clk_i;
   initial begin
      u_hbadt_if.bclk = 1'b0;
      #0.7;
      forever #24 u_hbadt_if.bclk = ~u_hbadt_if.bclk;
   end
   always @(negedge clk_i) begin
      if (u_hbadt_if.line.host_data_valid && !dv_q) begin
         inv0 = u_hbadt_if.line.data_group_inversion_flags;
      end
      dv_q = u_hbadt_if.line.host_data_valid;
      if (rd_early_o) early_seen = 1'b1;
      dones += int'(snoop_done_o) + int'(cpu_done_o) + int'(wr_done_o) + int'(rd_done_o);
   end

   // =====================================================================
   // helpers
   function automatic hbadt_abeats_t mk_a(input hbadt_addr_t a);
      return {~a, a};
   endfunction
   function automatic hbadt_dbeats_t mk_d(input hbadt_data_t d);
      return {~d, {d[31:0], d[63:32]}, d ^ 64'h5555_5555_5555_5555, d};
   endfunction
   function automatic logic flag(input int k);
      case (k)
         0: return cpu_addr_valid_o;
         1: return wr_data_valid_o;
         2: return snoop_valid_o;
         default: return rd_valid_o;
      endcase
   endfunction
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic await(input int k);
      int n;
      n = 0;
      while (flag(k) !== 1'b1 && n < 80) begin
         @(negedge clk_i);
         n++;
      end
      chk(256'(n < 80), 256'h1);
   endtask
   // request bits: read, snoop, write, processor address
   task automatic pulse(input logic [3:0] m);
      @(negedge clk_i);
      {rd_req_i, snoop_go_i, wr_go_i, cpu_go_i} = m;
      @(negedge clk_i);
      {snoop_go_i, wr_go_i, cpu_go_i} = 3'h0;
      for (int n = 0; n < 40 && rd_req_i && rd_ack_o !== 1'b1; n++) @(negedge clk_i);
      rd_req_i = 1'b0;
   endtask
   task automatic end_sim;
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   initial begin
      {clk_i, srst_i, cpu_go_i, wr_go_i, snoop_go_i, rd_req_i, dv_q, early_seen} = 8'h40;
      {cpu_addr_i, snoop_addr_i, wr_data_i, rd_data_i} = '0;
      {fail_count, comparisons, dones} = '0;
      repeat (16) @(negedge clk_i);
      chk(256'(u_hbadt_if.line), 256'(PINS_IDLE));
      srst_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         cpu_addr_i = mk_a(ROWS[i].a);
         snoop_addr_i = mk_a(ROWS[i].a);
         wr_data_i = mk_d(ROWS[i].d);
         rd_data_i = mk_d(ROWS[i].d);
         for (int k = 0; k < 4; k++) begin
            early_seen = 1'b0;
            pulse(4'(1 << k));
            await(k);
            if (k == 0) chk(256'(cpu_addr_o), 256'(mk_a(ROWS[i].a)));
            if (k == 1) chk(256'(wr_data_o), 256'(mk_d(ROWS[i].d)));
            if (k == 2) chk(256'(snoop_addr_o), 256'(mk_a(ROWS[i].a)));
            if (k == 3) chk(256'(rd_data_o), 256'(mk_d(ROWS[i].d)));
            if (k[0]) chk(256'(inv0), 256'(ROWS[i].inv));
            if (k == 3) chk(256'(early_seen), 256'h1);
            chk(256'({snoop_busy_o, cpu_busy_o, wr_busy_o}), 256'h0);
            repeat (6) @(negedge clk_i);
         end
      end
      // second address request while busy is ignored
      cpu_addr_i = mk_a(29'h0abc_def0);
      pulse(4'h1);
      cpu_addr_i = mk_a(29'h1234_5678);
      pulse(4'h1);
      cnt = 0;
      repeat (60) begin
         @(negedge clk_i);
         cnt += int'(cpu_addr_valid_o);
      end
      chk(256'(cnt), 256'h1);
      chk(256'(cpu_addr_o), 256'(mk_a(29'h0abc_def0)));
      // address and write data together
      wr_data_i = mk_d(ROWS[2].d);
      pulse(4'h3);
      await(0);
      await(1);
      chk(256'(cpu_addr_o), 256'(mk_a(29'h1234_5678)));
      chk(256'(wr_data_o), 256'(mk_d(ROWS[2].d)));
      // reset in mid write, then a read
      repeat (6) @(negedge clk_i);
      wr_data_i = mk_d(ROWS[0].d);
      pulse(4'h2);
      for (int n = 0; n < 40 && u_hbadt_if.host_oe.data !== 1'b1; n++) @(negedge clk_i);
      @(negedge clk_i);
      srst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk(256'(u_hbadt_if.line), 256'(PINS_IDLE));
      chk(256'({wr_busy_o, u_hbadt_if.dev_oe, u_hbadt_if.host_oe}), 256'h0);
      srst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rd_data_i = mk_d(ROWS[1].d);
      pulse(4'h8);
      await(3);
      chk(256'(rd_data_o), 256'(mk_d(ROWS[1].d)));
      chk(256'(inv0), 256'(ROWS[1].inv));
      chk(256'(dones), 256'h14);
      end_sim();
   end

   // =====================================================================
   // watchdog
   initial begin
      #60000;
      fail_count++;
      end_sim();
   end
endmodule
